// ==== core/pcf_channel.sv ====
// Overview of operation
// R1: fifo-mode select bit 0 routes captured phases into the fifo.
// R2: fifo status bit 4 reads one while the fifo is empty.
// R3: watermark status bit 2 sets at almost-full level; write one clears.
// R4: overflow status bit 1 sets when a phase arrives with fifo full.
// R5: full status bit 0 sets when the fifo becomes full; write one clears.
// R6: 20-bit timeout in pwm clocks sets status bit 3; write one clears.
// R7: fifo entry bit 31 is the measured phase level.
// R8: fifo entry bits 30:0 hold the phase length in pwm clocks.
// R9: software disables the channel before changing clock settings.
// R10: on capture interrupt software reads high or low count by polarity flag.
// R11: dma capture only on this channel, configured before enabling.
// R12: dma mode raises a request; the dma controller drains the counts.
// R13: one-shot end raises channel interrupt and clears the enable bit.
// R14: software sets repeat count and interrupt enable for one-shot use.
// R15: low-power bit with channel inactive stops the prescaler clock.
// R16: software leaves low power only with the channel disabled.
// R17: new period and duty take effect when the current period ends; with conlock set the old values are kept.
// R18: mode or divider changes while active are accepted immediately.
// R19: pwm clock is clock/2^prescale, optionally /2*scale, scale 0 means 512.
// R20: mode 00 one-shot, 01 continuous, 10 capture.
// R21: repeat count n gives n+1 periods in one-shot mode.
// R22: fifo control bits 6:4 hold the almost-full watermark.
// R23: each finished input phase pushes one entry; reading the entry pops it.
// R24: fifo interrupt is the or of enabled fifo status bits.
`include "pcf_regs.svh"

module pcf_channel #(
  parameter int FIFO_DEPTH = 8,
  parameter int FIFO_AW    = 3
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic [31:0]      o_hrdata,
  output logic             o_hresp,
  // two-way waveform pin
  input  wire logic        i_pwm_pin,
  output logic             o_pwm_pin,
  output logic             o_pwm_pin_oe,
  // interrupts, dma and power
  output logic             o_ch_irq,
  output logic             o_fifo_irq,
  output logic             o_dma_req,
  output logic             o_prescale_gated
);
  import pcf_pkg::*;

  // ==========================================================
  // registers
  pcf_ctrl_type      ctrl;
  pcf_fifo_ctrl_type fctrl;
  pcf_req_type       req;
  pcf_bus_state_type bus_state;
  logic [31:0] period_prog, duty_prog, period_act, duty_act;
  logic [31:0] hpc_cap, lpc_cap, pwm_cnt;
  logic [19:0] tout_thr, tout_cnt;
  logic [3:0]  fifo_sts;
  logic        int_ch, int_pol, int_en;
  logic [7:0]  rpt_cnt;
  logic [6:0]  pre_cnt;
  logic [9:0]  sc_cnt;
  logic        sync1, sync2, sync3, in_lvl;
  logic [30:0] phase_cnt;
  logic [31:0] fifo_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_ptr, rd_ptr;
  logic [FIFO_AW:0]   fifo_cnt;

  // ==========================================================
  // bus decode
  logic wr_en, rd_cap, pop, accept;
  logic [31:0] rd_mux;
  assign accept = i_hsel && i_htrans[1] && i_hready;
  assign wr_en  = (bus_state == BUS_WR);
  assign rd_cap = (bus_state == BUS_RD_WAIT);
  assign pop    = rd_cap && (req.addr == `PCF_OFS_FIFO_ENTRY) && (fifo_cnt != '0); // see R23
  assign o_hreadyout = (bus_state != BUS_RD_WAIT);
  assign o_hresp     = 1'b0;

  function automatic logic wr_to(input logic [7:0] ofs);
    wr_to = wr_en && (req.addr == ofs);
  endfunction

  // ==========================================================
  // clock divider chain
  logic run_pre, pre_tick, sc_tick, pwm_tick;
  logic [9:0] sc_lim;
  assign run_pre  = !(ctrl.power_saving_on && !ctrl.enable);   // see R15
  assign o_prescale_gated = !run_pre;
  assign pre_tick = run_pre && (pre_cnt == 7'((8'd1 << ctrl.prescale) - 8'd1)); // see R19
  assign sc_lim   = (ctrl.scale == 8'h00) ? `PCF_SCALE_ZERO_DIV : {1'b0, ctrl.scale, 1'b0};
  assign sc_tick  = pre_tick && (sc_cnt == sc_lim - 10'd1);
  assign pwm_tick = ctrl.clk_sel ? sc_tick : pre_tick;

  // prescaler; a divider change mid-run keeps the running count, which restarts at its tick or, if already past the new limit, at its 7-bit wrap (see R18)
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_cnt <= '0;
    end else if (pre_tick || !run_pre) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 7'd1;
    end
  end

  // scaler on the prescaled pulse
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sc_cnt <= '0;
    end else if (sc_tick || sc_cnt >= sc_lim) begin
      sc_cnt <= '0;
    end else if (pre_tick) begin
      sc_cnt <= sc_cnt + 10'd1;
    end
  end

  // ==========================================================
  // waveform generation
  logic gen_mode, cap_mode, per_end, last_rpt, active, shot_done;
  logic [31:0] per_h, dut_h;
  assign cap_mode  = ctrl.enable && (ctrl.mode == `PCF_MODE_CAPTURE);  // see R20
  assign gen_mode  = ctrl.enable && (ctrl.mode == `PCF_MODE_ONESHOT || ctrl.mode == `PCF_MODE_CONT);
  assign per_end   = gen_mode && pwm_tick && (pwm_cnt + 32'd1 >= period_act);
  assign last_rpt  = (rpt_cnt == ctrl.rpt);                          // see R21
  assign shot_done = per_end && (ctrl.mode == `PCF_MODE_ONESHOT) && last_rpt;
  assign per_h     = {1'b0, period_act[31:1]};
  assign dut_h     = {1'b0, duty_act[31:1]};
  assign active    = ctrl.center_mode ? (pwm_cnt >= per_h - dut_h && pwm_cnt < per_h + dut_h)
                                      : (pwm_cnt < duty_act);

  // period counter, also the free count in capture mode
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwm_cnt <= '0;
    end else if (!ctrl.enable || per_end) begin
      pwm_cnt <= '0;
    end else if (pwm_tick) begin
      pwm_cnt <= pwm_cnt + 32'd1;
    end
  end

  // shadow period and duty load at period end or while disabled, unless conlock is set, so a cycle is never torn
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      period_act <= '0;
      duty_act   <= '0;
    end else if ((!ctrl.enable || per_end) && !ctrl.conlock) begin // see R17
      period_act <= ctrl.center_mode ? {period_prog[31:1], 1'b0} : period_prog;
      duty_act   <= ctrl.center_mode ? {duty_prog[31:1], 1'b0} : duty_prog;
    end
  end

  // repeat counter for one-shot bursts
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rpt_cnt <= '0;
    end else if (!ctrl.enable || shot_done) begin
      rpt_cnt <= '0;
    end else if (per_end) begin
      rpt_cnt <= rpt_cnt + 8'd1;
    end
  end

  // pin output registered; driven only when not measuring
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pwm_pin    <= 1'b0;
      o_pwm_pin_oe <= 1'b0;
    end else begin
      o_pwm_pin    <= gen_mode ? (active ? ctrl.duty_pol : !ctrl.duty_pol) : ctrl.inactive_pol;
      o_pwm_pin_oe <= (ctrl.mode != `PCF_MODE_CAPTURE);
    end
  end

  // ==========================================================
  // capture of input phases
  logic phase_end;
  pcf_entry_type entry;
  assign phase_end = cap_mode && (sync2 == sync3) && (sync3 != in_lvl);
  assign entry     = '{pol: in_lvl, cycles: phase_cnt + {30'h0, pwm_tick}}; // closing tick counts too, see R7 see R8

  // three-stage synchroniser; level accepted once stages two and three agree
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1  <= 1'b0;
      sync2  <= 1'b0;
      sync3  <= 1'b0;
      in_lvl <= 1'b0;
    end else begin
      sync1 <= i_pwm_pin;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        in_lvl <= sync3;
      end
    end
  end

  // phase length in pwm clocks
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_cnt <= '0;
    end else if (!cap_mode || phase_end) begin
      phase_cnt <= '0;
    end else if (pwm_tick) begin
      phase_cnt <= phase_cnt + 31'd1;
    end
  end

  // single high and low capture registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hpc_cap <= '0;
      lpc_cap <= '0;
    end else if (phase_end) begin
      if (in_lvl) begin
        hpc_cap <= {1'b0, entry.cycles};
      end else begin
        lpc_cap <= {1'b0, entry.cycles};
      end
    end
  end

  // ==========================================================
  // measurement fifo
  logic push, fifo_full, fifo_empty, wm_hit;
  assign fifo_full  = (fifo_cnt == (FIFO_AW+1)'(FIFO_DEPTH));
  assign fifo_empty = (fifo_cnt == '0);                              // see R2
  assign push       = phase_end && fctrl.fifo_mode_sel && !fifo_full; // see R1 see R23
  assign wm_hit     = (fifo_cnt >= (FIFO_AW+1)'(fctrl.watermark));   // see R22
  assign o_dma_req  = fctrl.dma_mode_en && fctrl.fifo_mode_sel && !fifo_empty && wm_hit; // see R11 see R12

  // storage, written only on a push
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      fifo_mem[wr_ptr] <= entry;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      fifo_cnt <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      fifo_cnt <= fifo_cnt + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop);
    end
  end

  // timeout counts pwm clocks while data waits unread
  logic tout_fire;
  assign tout_fire = fctrl.timeout_en && !fifo_empty && pwm_tick && (tout_thr != '0)
                     && (tout_cnt == tout_thr - 20'd1);                // see R6
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tout_cnt <= '0;
    end else if (push || pop || fifo_empty || tout_fire) begin
      tout_cnt <= '0;
    end else if (pwm_tick && fctrl.timeout_en) begin
      tout_cnt <= tout_cnt + 20'd1;
    end
  end

  // sticky fifo events; a set in the clearing cycle wins
  logic [3:0] sts_set, sts_clr;
  assign sts_set[`PCF_STS_FULL_BIT] = push && (fifo_cnt == (FIFO_AW+1)'(FIFO_DEPTH - 1)); // see R5
  assign sts_set[`PCF_STS_OVF_BIT]  = phase_end && fctrl.fifo_mode_sel && fifo_full;     // see R4
  assign sts_set[`PCF_STS_WM_BIT]   = push && (fifo_cnt + 1'b1 >= (FIFO_AW+1)'(fctrl.watermark)); // see R3
  assign sts_set[`PCF_STS_TOUT_BIT] = tout_fire;
  assign sts_clr = wr_to(`PCF_OFS_FIFO_STS) ? i_hwdata[3:0] : 4'h0;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fifo_sts <= '0;
    end else begin
      fifo_sts <= (fifo_sts & ~sts_clr) | sts_set;                    // see R3 see R4 see R5 see R6
    end
  end
  assign o_fifo_irq = |(fifo_sts & {fctrl.timeout_en, fctrl.wm_int_en, fctrl.ovf_int_en, fctrl.full_int_en}); // see R24

  // channel interrupt and polarity flag
  logic ch_set;
  assign ch_set = shot_done || phase_end;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_ch  <= 1'b0;
      int_pol <= 1'b0;
    end else if (ch_set) begin
      int_ch  <= 1'b1;                                                // see R13
      int_pol <= phase_end ? in_lvl : int_pol;
    end else if (wr_to(`PCF_OFS_INT_STS) && i_hwdata[`PCF_INT_CH_BIT]) begin
      int_ch  <= 1'b0;
      int_pol <= 1'b0;
    end
  end
  assign o_ch_irq = int_ch && int_en;

  // ==========================================================
  // software registers; one-shot end clears enable unless rewritten
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl        <= `PCF_RST_WORD;
      fctrl       <= `PCF_RST_WORD;
      period_prog <= `PCF_RST_WORD;
      duty_prog   <= `PCF_RST_WORD;
      tout_thr    <= '0;
      int_en      <= 1'b0;
    end else begin
      if (wr_to(`PCF_OFS_CTRL)) begin
        ctrl <= i_hwdata & `PCF_CTRL_WMASK;                           // see R18
      end else if (shot_done) begin
        ctrl.enable <= 1'b0;                                          // see R13
      end
      if (wr_to(`PCF_OFS_FIFO_CTRL)) begin
        fctrl <= i_hwdata & `PCF_FCTRL_WMASK;
      end
      if (wr_to(`PCF_OFS_PERIOD)) begin
        period_prog <= i_hwdata;
      end
      if (wr_to(`PCF_OFS_DUTY)) begin
        duty_prog <= i_hwdata;
      end
      if (wr_to(`PCF_OFS_TOUT)) begin
        tout_thr <= i_hwdata[19:0];
      end
      if (wr_to(`PCF_OFS_INT_EN)) begin
        int_en <= i_hwdata[`PCF_INT_CH_BIT];
      end
    end
  end

  // ==========================================================
  // read mux; capture mode shows measured counts
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (req.addr)
      `PCF_OFS_COUNT:      rd_mux = pwm_cnt;
      `PCF_OFS_PERIOD:     rd_mux = (ctrl.mode == `PCF_MODE_CAPTURE) ? hpc_cap : period_prog;
      `PCF_OFS_DUTY:       rd_mux = (ctrl.mode == `PCF_MODE_CAPTURE) ? lpc_cap : duty_prog;
      `PCF_OFS_CTRL:       rd_mux = ctrl;
      `PCF_OFS_INT_STS:    rd_mux = {20'h0, int_pol, 7'h0, int_ch, 3'h0};
      `PCF_OFS_INT_EN:     rd_mux = {28'h0, int_en, 3'h0};
      `PCF_OFS_FIFO_CTRL:  rd_mux = fctrl;
      `PCF_OFS_FIFO_STS:   rd_mux = {27'h0, fifo_empty, fifo_sts};
      `PCF_OFS_TOUT:       rd_mux = {12'h0, tout_thr};
      `PCF_OFS_FIFO_ENTRY: rd_mux = fifo_empty ? 32'h0000_0000 : fifo_mem[rd_ptr];
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // bus phases; reads take one wait state so the data leaves a flop
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_state <= BUS_IDLE;
      req       <= '0;
      o_hrdata  <= '0;
    end else begin
      unique case (bus_state)
        BUS_RD_WAIT: begin
          o_hrdata  <= rd_mux;
          bus_state <= BUS_RD_DONE;
        end
        BUS_IDLE, BUS_WR, BUS_RD_DONE: begin
          if (accept) begin
            req       <= '{addr: i_haddr[7:0], write: i_hwrite};
            bus_state <= i_hwrite ? BUS_WR : BUS_RD_WAIT;
          end else begin
            bus_state <= BUS_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// ==== core/pcf_regs.svh ====
`ifndef PCF_REGS_SVH
`define PCF_REGS_SVH

// ==========================================================
// register byte offsets
`define PCF_OFS_COUNT      8'h30
`define PCF_OFS_PERIOD     8'h34
`define PCF_OFS_DUTY       8'h38
`define PCF_OFS_CTRL       8'h3c
`define PCF_OFS_INT_STS    8'h40
`define PCF_OFS_INT_EN     8'h44
`define PCF_OFS_FIFO_CTRL  8'h50
`define PCF_OFS_FIFO_STS   8'h54
`define PCF_OFS_TOUT       8'h58
`define PCF_OFS_FIFO_ENTRY 8'h60

// ==========================================================
// field positions
`define PCF_STS_FULL_BIT   0
`define PCF_STS_OVF_BIT    1
`define PCF_STS_WM_BIT     2
`define PCF_STS_TOUT_BIT   3
`define PCF_STS_EMPTY_BIT  4
`define PCF_INT_CH_BIT     3
`define PCF_INT_POL_BIT    11
`define PCF_ENTRY_POL_BIT  31

// ==========================================================
// writable masks and reset values
`define PCF_CTRL_WMASK     32'hffff_737f
`define PCF_FCTRL_WMASK    32'h0000_037f
`define PCF_TOUT_WMASK     32'h000f_ffff
`define PCF_RST_WORD       32'h0000_0000

// ==========================================================
// operating mode codes and scale limits
`define PCF_MODE_ONESHOT   2'b00
`define PCF_MODE_CONT      2'b01
`define PCF_MODE_CAPTURE   2'b10
`define PCF_SCALE_ZERO_DIV 10'd512

`endif

// ==== core/pcf_pkg.sv ====
package pcf_pkg;

  // ==========================================================
  // control word of the channel
  typedef struct packed {
    logic [7:0] rpt;
    logic [7:0] scale;
    logic       rsv15;
    logic [2:0] prescale;
    logic [1:0] rsv11;
    logic       clk_sel;
    logic       power_saving_on;
    logic       rsv7;
    logic       conlock;
    logic       center_mode;
    logic       inactive_pol;
    logic       duty_pol;
    logic [1:0] mode;
    logic       enable;
  } pcf_ctrl_type;

  // ==========================================================
  // fifo control word
  typedef struct packed {
    logic [21:0] rsv10;
    logic        timeout_en;
    logic        dma_mode_en;
    logic        rsv7;
    logic [2:0]  watermark;
    logic        wm_int_en;
    logic        ovf_int_en;
    logic        full_int_en;
    logic        fifo_mode_sel;
  } pcf_fifo_ctrl_type;

  // ==========================================================
  // one captured phase and one latched bus request
  typedef struct packed {
    logic        pol;
    logic [30:0] cycles;
  } pcf_entry_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
  } pcf_req_type;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD_WAIT, BUS_RD_DONE} pcf_bus_state_type;

endpackage

// ==== tb/pcf_channel_properties.sv ====
module pcf_channel_properties (
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  // bus side
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [2:0]  i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hresp,
  // pin, interrupts, dma and power
  input wire logic        i_pwm_pin,
  input wire logic        o_pwm_pin,
  input wire logic        o_pwm_pin_oe,
  input wire logic        o_ch_irq,
  input wire logic        o_fifo_irq,
  input wire logic        o_dma_req,
  input wire logic        o_prescale_gated
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // helper logic
  logic       rd_taken;
  logic       wr_taken;
  logic       pin_q;
  logic [3:0] since_chg;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // transfer accepted at this edge
  assign rd_taken = i_hsel & i_htrans[1] & i_hready & !i_hwrite;
  assign wr_taken = i_hsel & i_htrans[1] & i_hready & i_hwrite;
  // cycles since the pin last moved, saturating so it never wraps
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_q     <= 1'b0;
      since_chg <= 4'hf;
    end else begin
      pin_q     <= i_pwm_pin;
      since_chg <= (pin_q != i_pwm_pin) ? 4'h0 : ((since_chg == 4'hf) ? 4'hf : since_chg + 4'h1);
    end
  end
  // ==========================================================
  // assertions
  a_write_no_wait: assert property (wr_taken |=> o_hreadyout)
    else $error("write data phase stalled");
  a_read_one_wait: assert property (rd_taken |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");
  a_resp_always_okay: assert property (o_hresp == 1'b0)
    else $error("error response seen");
  a_rdata_holds: assert property (o_hreadyout && $past(o_hreadyout) |-> $stable(o_hrdata))
    else $error("read data moved outside a read");
  a_dma_in_capture: assert property (o_dma_req |-> !o_pwm_pin_oe)
    else $error("dma request outside capture");
  a_oneshot_idle: assert property ($rose(o_ch_irq) && o_pwm_pin_oe |-> ##2 $stable(o_pwm_pin)[*3])
    else $error("output moved after burst end");
  a_phase_irq_cause: assert property ($rose(o_ch_irq) && !o_pwm_pin_oe |-> since_chg <= 4'd8)
    else $error("capture interrupt without pin edge");
  a_gate_quiet: assert property (o_prescale_gated && $past(o_prescale_gated) && o_pwm_pin_oe |-> $stable(o_pwm_pin))
    else $error("output moved while gated");
  // main scenarios reached
  c_read: cover property (rd_taken);
  c_dma: cover property ($rose(o_dma_req));
  c_burst_end: cover property ($rose(o_ch_irq) && o_pwm_pin_oe);
endmodule

bind pcf_channel pcf_channel_properties pcf_channel_properties_i (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp), .i_pwm_pin(i_pwm_pin),
  .o_pwm_pin(o_pwm_pin), .o_pwm_pin_oe(o_pwm_pin_oe), .o_ch_irq(o_ch_irq), .o_fifo_irq(o_fifo_irq),
  .o_dma_req(o_dma_req), .o_prescale_gated(o_prescale_gated)
);

// ==== tb/pcf_pin_source.sv ====
module pcf_pin_source (
  // clock and control
  input  wire logic        i_ref_clk,
  input  wire logic        i_run,
  input  wire logic [7:0]  i_high_len,
  input  wire logic [7:0]  i_low_len,
  // design side of the pin
  input  wire logic        i_pwm_pin,
  input  wire logic        i_pwm_pin_oe,
  output logic             o_wire,
  output logic [15:0]      o_rise_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // measured source and output load
  logic       src = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic       last_wire = 1'b0;
  // the design wins the wire while it drives it
  assign o_wire = i_pwm_pin_oe ? i_pwm_pin : src;
  // stop only after a low phase, so no partial high phase is cut off
  always @(posedge i_ref_clk) begin
    if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (src) begin
      src <= 1'b0;
      cnt <= i_low_len - 8'h01;
    end else if (i_run) begin
      src <= 1'b1;
      cnt <= i_high_len - 8'h01;
    end
  end
  // count rising edges the design drives, one per output period
  initial o_rise_count = 16'h0000;
  always @(posedge i_ref_clk) begin
    last_wire <= o_wire;
    if (o_wire && !last_wire && i_pwm_pin_oe) o_rise_count <= o_rise_count + 16'h0001;
  end
endmodule

// ==== tb/pwm_channel_capture_fifo_tb_top.sv ====
`include "pcf_regs.svh"

module pwm_channel_capture_fifo_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  localparam logic [7:0] FIFO_EVENT_STATUS  = 8'h54;
  localparam logic [7:0] FIFO_TIMEOUT_LIMIT = 8'h58;
  localparam logic [7:0] FIFO_CAPTURE_ENTRY = 8'h60;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0]  i_htrans = 2'h0;
  logic        i_hwrite = 1'b0;
  logic [31:0] i_hwdata = 32'h0;
  logic        o_hreadyout, o_hresp, o_pwm_pin, o_pwm_pin_oe;
  logic        o_ch_irq, o_fifo_irq, o_dma_req, o_prescale_gated;
  logic [31:0] o_hrdata;
  logic        pin_wire;
  logic        src_run = 1'b0;
  logic [15:0] rises;
  logic        rdy_n = 1'b1;
  logic [31:0] rdata_n = 32'h0;
  int          bad_count = 0;
  int          n_tests = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  // bus answer sampled mid-cycle, settled for the coming edge
  always @(negedge i_ref_clk) begin
    rdy_n   <= o_hreadyout;
    rdata_n <= o_hrdata;
  end
  pcf_channel pcf_channel_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp), .i_pwm_pin(pin_wire),
    .o_pwm_pin(o_pwm_pin), .o_pwm_pin_oe(o_pwm_pin_oe), .o_ch_irq(o_ch_irq), .o_fifo_irq(o_fifo_irq),
    .o_dma_req(o_dma_req), .o_prescale_gated(o_prescale_gated)
  );
  pcf_pin_source pcf_pin_source_i (
    .i_ref_clk(i_ref_clk), .i_run(src_run), .i_high_len(8'd20), .i_low_len(8'd30),
    .i_pwm_pin(o_pwm_pin), .i_pwm_pin_oe(o_pwm_pin_oe), .o_wire(pin_wire), .o_rise_count(rises)
  );
  // ==========================================================
  // shared tasks
  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask
  // one single transfer; address held until hready, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    i_hsel   <= 1'b1;
    i_haddr  <= {24'h0, a};
    i_hwrite <= wr;
    i_htrans <= 2'h2;
    do begin @(posedge i_ref_clk); n++; end while (!rdy_n && n < 50);
    i_hsel   <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wr ? wd : 32'h0;
    do begin @(posedge i_ref_clk); n++; end while (!rdy_n && n < 100);
    rd = rdata_n;
    if (!rdy_n) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(name, v, exp);
  endtask
  // ==========================================================
  // scenarios
  task automatic scn_registers();
    rd_chk("status at reset", FIFO_EVENT_STATUS, 32'h10);
    rd_chk("timeout at reset", FIFO_TIMEOUT_LIMIT, 32'h0);
    wr(FIFO_TIMEOUT_LIMIT, 32'hffff_ffff);
    rd_chk("timeout width", FIFO_TIMEOUT_LIMIT, 32'h000f_ffff);
    wr(FIFO_CAPTURE_ENTRY, 32'h1234_5678);
    rd_chk("entry when empty", FIFO_CAPTURE_ENTRY, 32'h0);
    wr(8'h7c, 32'hffff_ffff);
    rd_chk("unmapped offset", 8'h7c, 32'h0);
    wr(`PCF_OFS_FIFO_CTRL, 32'hffff_ffff);
    rd_chk("fifo ctrl bits", `PCF_OFS_FIFO_CTRL, 32'h37f);
  endtask
  // fill past full with 20 high / 30 low phases, then drain
  task automatic scn_capture();
    logic [31:0] v = 32'h0;
    int n;
    wr(`PCF_OFS_CTRL, 32'h0);
    wr(`PCF_OFS_CTRL, 32'h4);
    wr(FIFO_TIMEOUT_LIMIT, 32'h10);
    wr(`PCF_OFS_FIFO_CTRL, 32'h32f);
    wr(`PCF_OFS_INT_EN, 32'h8);
    wr(`PCF_OFS_CTRL, 32'h5);
    src_run <= 1'b1;
    for (n = 0; n < 2000 && !o_dma_req; n++) @(posedge i_ref_clk);
    check("dma request", {31'h0, o_dma_req}, 32'h1);
    for (n = 0; n < 300 && !v[0]; n++) bus(1'b0, FIFO_EVENT_STATUS, 32'h0, v);
    repeat (60) @(posedge i_ref_clk);
    src_run <= 1'b0;
    repeat (80) @(posedge i_ref_clk);
    rd_chk("status full", FIFO_EVENT_STATUS, 32'h0f);
    check("fifo irq set", {31'h0, o_fifo_irq}, 32'h1);
    rd_chk("polarity flag", `PCF_OFS_INT_STS, 32'h808);
    rd_chk("high phase", `PCF_OFS_PERIOD, 32'd20);
    rd_chk("low phase", `PCF_OFS_DUTY, 32'd30);
    bus(1'b0, FIFO_CAPTURE_ENTRY, 32'h0, v);
    check("first entry level", {31'h0, v[31]}, 32'h0);
    for (n = 1; n < 8; n++) begin
      bus(1'b0, FIFO_CAPTURE_ENTRY, 32'h0, v);
      check("fifo entry", v, n[0] ? {1'b1, 31'd20} : {1'b0, 31'd30});
    end
    rd_chk("status drained", FIFO_EVENT_STATUS, 32'h1f);
    check("dma idle", {31'h0, o_dma_req}, 32'h0);
    wr(FIFO_EVENT_STATUS, 32'h0f);
    rd_chk("status cleared", FIFO_EVENT_STATUS, 32'h10);
    check("fifo irq clear", {31'h0, o_fifo_irq}, 32'h0);
    wr(`PCF_OFS_CTRL, 32'h0);
    wr(`PCF_OFS_INT_STS, 32'h8);
  endtask
  // repeat count 2 means three periods, then enable drops
  task automatic scn_oneshot();
    logic [15:0] base;
    int n;
    wr(`PCF_OFS_PERIOD, 32'd10);
    wr(`PCF_OFS_DUTY, 32'd4);
    wr(`PCF_OFS_CTRL, 32'h0200_0008);
    base = rises;
    wr(`PCF_OFS_CTRL, 32'h0200_0009);
    for (n = 0; n < 1000 && !o_ch_irq; n++) @(posedge i_ref_clk);
    repeat (3) @(posedge i_ref_clk);
    check("burst irq", {31'h0, o_ch_irq}, 32'h1);
    check("burst periods", {16'h0, rises - base}, 32'd3);
    rd_chk("enable cleared", `PCF_OFS_CTRL, 32'h0200_0008);
    wr(`PCF_OFS_INT_STS, 32'h8);
    repeat (2) @(posedge i_ref_clk);
    check("burst irq clear", {31'h0, o_ch_irq}, 32'h0);
  endtask
  task automatic scn_power();
    logic [15:0] base;
    wr(`PCF_OFS_CTRL, 32'h100);
    repeat (2) @(posedge i_ref_clk);
    check("prescaler gated", {31'h0, o_prescale_gated}, 32'h1);
    wr(`PCF_OFS_CTRL, 32'h0);
    base = rises;
    wr(`PCF_OFS_CTRL, 32'h0001_1203);
    repeat (120) @(posedge i_ref_clk);
    check("gate released", {31'h0, o_prescale_gated}, 32'h0);
    check("divided periods", {16'h0, rises - base}, 32'd3);
    wr(`PCF_OFS_CTRL, 32'h0);
  endtask
  // ==========================================================
  // main sequence and hang guard
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    scn_registers();
    scn_capture();
    scn_oneshot();
    scn_power();
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge i_ref_clk);
    bad_count++;
    finish_test();
  end
endmodule
